// ---- exec_pkg.sv ----
// Package with opcodes, widths and reset values for the return/rotate/OR execution block.
package exec_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W   = 11;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ACCUMULATOR_OR_INTO_MEMORY,
    OP_SUBROUTINE_EXIT,
    OP_SUBROUTINE_EXIT_WITH_LITERAL,
    OP_INTERRUPT_EXIT,
    OP_MEMORY_ROTATE_LEFT
  } exec_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM_WRITE,
    ST_VECTOR
  } exec_state_t;

  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET   = 11'h000;
  localparam logic              MIE_RESET  = 1'h0;
  localparam logic              ZERO_RESET = 1'h0;
  localparam int                MSB_POS    = DATA_W - 1;

endpackage : exec_pkg

// ---- byte_alu.sv ----
// Combinational byte operations: OR, rotate left and zero detect.
`timescale 1ns/1ps
module byte_alu
  import exec_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input  wire logic             rotate_sel,
  input  wire logic [WIDTH-1:0] acc_value,
  input  wire logic [WIDTH-1:0] mem_value,
  output logic      [WIDTH-1:0] result,
  output logic                  result_zero
);

  // A rotate needs at least two bits to move anything.
  if (WIDTH < 2) begin : g_bad_width
    $error("byte_alu: WIDTH must be at least 2");
  end

  logic [WIDTH-1:0] rotated;

  // Each bit moves up one place; the top bit wraps into bit zero.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_rot
      if (i == 0) begin : g_wrap
        assign rotated[0] = mem_value[WIDTH-1];
      end else begin : g_shift
        assign rotated[i] = mem_value[i-1];
      end
    end
  endgenerate

  always_comb begin
    result      = rotate_sel ? rotated : (acc_value | mem_value);
    result_zero = (result == '0);
  end

endmodule : byte_alu

// ---- exec_unit.sv ----
// Execution of memory OR, rotate left, subroutine and interrupt exits with interrupt gating.
//
// How it works
// - Memory OR writes accumulator OR byte back to memory, updates only zero flag.
// - Subroutine exit loads program counter from stack top, flags unchanged.
// - Exit with literal restores program counter and loads immediate into accumulator.
// - Interrupt exit restores program counter and sets master interrupt enable to one.
// - Interrupt pending at interrupt exit is serviced before main program resumes.
// - Master interrupt enable gates all interrupts; cleared means none serviced.
// - Rotate left moves bit i to i+1 and bit 7 into bit 0.
`timescale 1ns/1ps
module exec_unit
  import exec_pkg::*;
#(
  parameter int                DW         = DATA_W,
  parameter int                AW         = PC_W,
  parameter logic [PC_W-1:0]   INT_VECTOR = 11'h004
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 op_valid,
  input  wire exec_pkg::exec_op_t   op_code,
  input  wire logic [DW-1:0]        op_literal,
  input  wire logic [DW-1:0]        mem_rdata,
  input  wire logic [AW-1:0]        stack_top,
  input  wire logic                 int_request,
  input  wire logic                 mie_clear,
  output logic                      busy,
  output logic                      mem_we,
  output logic [DW-1:0]             mem_wdata,
  output logic                      stack_pop,
  output logic                      stack_push,
  output logic [AW-1:0]             push_addr,
  output logic                      pc_load,
  output logic [AW-1:0]             pc_value,
  output logic [DW-1:0]             acc,
  output logic                      zero_flag,
  output logic                      master_interrupt_enable,
  output logic                      int_ack
);

  import exec_pkg::*;

  // The reset constants and INT_VECTOR use the package widths, so other widths cannot be served.
  if (DW != DATA_W) begin : g_bad_dw
    $error("exec_unit: DW must equal DATA_W");
  end
  if (AW != PC_W) begin : g_bad_aw
    $error("exec_unit: AW must equal PC_W");
  end

  // The request pin comes from peripheral logic in another domain.
  logic int_sync1_reg;
  logic int_sync2_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      int_sync1_reg <= 1'h0;
      int_sync2_reg <= 1'h0;
    end else begin
      int_sync1_reg <= int_request;
      int_sync2_reg <= int_sync1_reg;
    end
  end

  exec_state_t       state_reg, state_next;
  logic [DW-1:0]     acc_reg, acc_next;
  logic              zero_reg, zero_next;
  logic              mie_reg, mie_next;
  logic [DW-1:0]     wdata_reg, wdata_next;
  logic              we_reg, we_next;
  logic              pop_reg, pop_next;
  logic              push_reg, push_next;
  logic [AW-1:0]     push_addr_reg, push_addr_next;
  logic              pc_load_reg, pc_load_next;
  logic [AW-1:0]     pc_reg, pc_next;
  logic              ack_reg, ack_next;
  logic              rot_sel_reg, rot_sel_next;
  // Busy is kept in its own flop so the output never carries a decode glitch.
  logic              busy_reg, busy_next;
  logic [DW-1:0]     alu_result;
  logic              alu_zero;

  byte_alu #(
    .WIDTH(DW)
  ) u_alu (
    .rotate_sel (rot_sel_reg),
    .acc_value  (acc_reg),
    .mem_value  (mem_rdata),
    .result     (alu_result),
    .result_zero(alu_zero)
  );

  always_comb begin
    state_next     = state_reg;
    acc_next       = acc_reg;
    zero_next      = zero_reg;
    mie_next       = mie_reg;
    wdata_next     = wdata_reg;
    we_next        = 1'h0;
    pop_next       = 1'h0;
    push_next      = 1'h0;
    push_addr_next = push_addr_reg;
    pc_load_next   = 1'h0;
    pc_next        = pc_reg;
    ack_next       = 1'h0;
    rot_sel_next   = rot_sel_reg;
    if (mie_clear) begin
      mie_next = 1'h0;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (op_valid) begin
          unique case (op_code)
            OP_ACCUMULATOR_OR_INTO_MEMORY: begin
              rot_sel_next = 1'h0;
              state_next   = ST_MEM_WRITE;
            end
            OP_MEMORY_ROTATE_LEFT: begin
              rot_sel_next = 1'h1;
              state_next   = ST_MEM_WRITE;
            end
            OP_SUBROUTINE_EXIT: begin
              pop_next     = 1'h1;
              pc_load_next = 1'h1;
              pc_next      = stack_top;
            end
            OP_SUBROUTINE_EXIT_WITH_LITERAL: begin
              pop_next     = 1'h1;
              pc_load_next = 1'h1;
              pc_next      = stack_top;
              acc_next     = op_literal;
            end
            OP_INTERRUPT_EXIT: begin
              pop_next     = 1'h1;
              pc_load_next = 1'h1;
              pc_next      = stack_top;
              mie_next     = 1'h1;
              // Set wins over a simultaneous clear so the exit is never undone.
              if (int_sync2_reg) begin
                state_next = ST_VECTOR;
              end
            end
            default: begin
            end
          endcase
        end else if (int_sync2_reg && mie_reg) begin
          push_addr_next = pc_reg;
          state_next     = ST_VECTOR;
        end
      end
      ST_MEM_WRITE: begin
        // The memory byte must still stand here, one cycle after issue.
        wdata_next = alu_result;
        we_next    = 1'h1;
        // Rotate leaves the zero flag alone; only the OR updates it.
        if (!rot_sel_reg) begin
          zero_next = alu_zero;
        end
        state_next = ST_IDLE;
      end
      ST_VECTOR: begin
        // The return address is saved and interrupts are masked until the next interrupt exit.
        push_next      = 1'h1;
        push_addr_next = pc_reg;
        pc_load_next   = 1'h1;
        pc_next        = INT_VECTOR;
        mie_next       = 1'h0;
        ack_next       = 1'h1;
        state_next     = ST_IDLE;
      end
    endcase
    busy_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      acc_reg       <= ACC_RESET;
      zero_reg      <= ZERO_RESET;
      mie_reg       <= MIE_RESET;
      wdata_reg     <= ZERO_BYTE;
      we_reg        <= 1'h0;
      pop_reg       <= 1'h0;
      push_reg      <= 1'h0;
      push_addr_reg <= PC_RESET;
      pc_load_reg   <= 1'h0;
      pc_reg        <= PC_RESET;
      ack_reg       <= 1'h0;
      rot_sel_reg   <= 1'h0;
      busy_reg      <= 1'h0;
    end else begin
      state_reg     <= state_next;
      acc_reg       <= acc_next;
      zero_reg      <= zero_next;
      mie_reg       <= mie_next;
      wdata_reg     <= wdata_next;
      we_reg        <= we_next;
      pop_reg       <= pop_next;
      push_reg      <= push_next;
      push_addr_reg <= push_addr_next;
      pc_load_reg   <= pc_load_next;
      pc_reg        <= pc_next;
      ack_reg       <= ack_next;
      rot_sel_reg   <= rot_sel_next;
      busy_reg      <= busy_next;
    end
  end

  assign busy                    = busy_reg;
  assign mem_we                  = we_reg;
  assign mem_wdata               = wdata_reg;
  assign stack_pop               = pop_reg;
  assign stack_push              = push_reg;
  assign push_addr               = push_addr_reg;
  assign pc_load                 = pc_load_reg;
  assign pc_value                = pc_reg;
  assign acc                     = acc_reg;
  assign zero_flag               = zero_reg;
  assign master_interrupt_enable = mie_reg;
  assign int_ack                 = ack_reg;

endmodule : exec_unit

// ---- exec_unit_assertions.sv ----
// Concurrent checks on the ports of the execution unit.
`timescale 1ns/1ps
module exec_unit_assertions
  import exec_pkg::*;
#(
  parameter int              DW         = DATA_W,
  parameter int              AW         = PC_W,
  parameter logic [PC_W-1:0] INT_VECTOR = 11'h004
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              op_valid,
  input wire exec_pkg::exec_op_t op_code,
  input wire logic [DW-1:0]     op_literal,
  input wire logic [DW-1:0]     mem_rdata,
  input wire logic [AW-1:0]     stack_top,
  input wire logic              int_request,
  input wire logic              busy,
  input wire logic              mem_we,
  input wire logic [DW-1:0]     mem_wdata,
  input wire logic              stack_pop,
  input wire logic              stack_push,
  input wire logic [AW-1:0]     push_addr,
  input wire logic              pc_load,
  input wire logic [AW-1:0]     pc_value,
  input wire logic [DW-1:0]     acc,
  input wire logic              zero_flag,
  input wire logic              master_interrupt_enable,
  input wire logic              int_ack
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic go = op_valid && !busy;
  wire logic ex = op_code inside {OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_WITH_LITERAL,
                                  OP_INTERRUPT_EXIT};
  a_exit_loads_pc: assert property (go && ex |=> pc_load && stack_pop &&
    pc_value == $past(stack_top)) else $error("exit did not restore pc");
  a_exit_keeps_zero: assert property (go && ex |=> $stable(zero_flag))
    else $error("exit changed zero flag");
  a_literal_to_acc: assert property (go && op_code == OP_SUBROUTINE_EXIT_WITH_LITERAL
    |=> acc == $past(op_literal)) else $error("literal not in accumulator");
  a_iexit_sets_enable: assert property (go && op_code == OP_INTERRUPT_EXIT
    |=> master_interrupt_enable) else $error("enable not set by interrupt exit");
  a_or_writes_mem: assert property (go && op_code == OP_ACCUMULATOR_OR_INTO_MEMORY
    |=> ##1 mem_we && mem_wdata == ($past(acc, 2) | $past(mem_rdata, 2)))
    else $error("memory or result wrong");
  a_or_zero_flag: assert property (go && op_code == OP_ACCUMULATOR_OR_INTO_MEMORY
    |=> ##1 zero_flag == (mem_wdata == ZERO_BYTE)) else $error("zero flag wrong");
  a_rotate_left: assert property (go && op_code == OP_MEMORY_ROTATE_LEFT |=> ##1 mem_we
    && mem_wdata == {$past(mem_rdata[DW-2:0], 2), $past(mem_rdata[DW-1], 2)})
    else $error("rotate result wrong");
  a_ack_needs_enable: assert property (int_ack |-> $past(master_interrupt_enable)
    && !master_interrupt_enable) else $error("interrupt taken while disabled");
  // Three samples of the request are needed so the two-stage synchroniser is surely full.
  a_pending_serviced: assert property (go && op_code == OP_INTERRUPT_EXIT && int_request
    && $past(int_request) && $past(int_request, 2) && !$past(rst) && !$past(rst, 2)
    |=> ##1 int_ack && stack_push && push_addr == $past(stack_top, 2)
    && pc_value == INT_VECTOR) else $error("pending interrupt not serviced");
endmodule : exec_unit_assertions

bind exec_unit exec_unit_assertions #(.DW(DW), .AW(AW), .INT_VECTOR(INT_VECTOR)) chk (
  .clock, .rst, .op_valid, .op_code, .op_literal, .mem_rdata, .stack_top, .int_request,
  .busy, .mem_we, .mem_wdata, .stack_pop, .stack_push, .push_addr, .pc_load, .pc_value,
  .acc, .zero_flag, .master_interrupt_enable, .int_ack);

// ---- tb.sv ----
// Self-checking bench for the execution unit.
`timescale 1ns/1ps
module tb;
  import exec_pkg::*;
  localparam logic [10:0] VEC = 11'h004;
  logic clock, rst, op_valid, int_request, mie_clear, busy, mem_we, stack_pop, stack_push;
  logic pc_load, zero_flag, master_interrupt_enable, int_ack, z;
  exec_op_t op_code;
  logic [7:0] op_literal, mem_rdata, mem_wdata, acc, a, m;
  logic [10:0] stack_top, push_addr, pc_value, acks;
  logic [31:0] seed = 32'hF1D7901B;
  int err_total = 0;
  int checks = 0;
  exec_unit #(.INT_VECTOR(VEC)) uut (.clock, .rst, .op_valid, .op_code, .op_literal,
    .mem_rdata, .stack_top, .int_request, .mie_clear, .busy, .mem_we, .mem_wdata, .stack_pop,
    .stack_push, .push_addr, .pc_load, .pc_value, .acc, .zero_flag,
    .master_interrupt_enable, .int_ack);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(string n, logic [10:0] seen, logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // Returns one nanosecond after the issue edge, where one-cycle answers already stand.
  // The strobe stays high, so back-to-back issues never write it twice in one time step.
  task automatic run(exec_op_t op, logic [7:0] lit, logic [7:0] md, logic [10:0] st);
    op_code = op; op_literal = lit; mem_rdata = md; stack_top = st; op_valid = 1'h1;
    @(posedge clock);
    #1;
  endtask : run
  // Drops the strobe and lets one more edge pass, keeping the memory byte in place.
  task automatic pause();
    op_valid = 1'h0;
    @(posedge clock);
    #1;
  endtask : pause
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  initial begin
    #500000 err_total++;
    print_verdict();
  end
  initial begin
    rst = 1'h1; op_valid = 1'h0; op_code = OP_NONE; op_literal = 8'h00; mem_rdata = 8'h00;
    stack_top = 11'h000; int_request = 1'h0; mie_clear = 1'h0;
    repeat (8) @(posedge clock);
    #1 rst = 1'h0;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 8'h00 : seed[7:0];
      m = (i == 0) ? 8'h00 : ((i == 1) ? 8'h80 : seed[15:8]);
      run(OP_SUBROUTINE_EXIT_WITH_LITERAL, a, m, seed[26:16]);
      check("pc", pc_value, seed[26:16]);
      check("acc", acc, a);
      run(OP_ACCUMULATOR_OR_INTO_MEMORY, 8'h00, m, 11'h000);
      check("busy", busy, 1'h1);
      pause();
      check("or", mem_wdata, a | m);
      check("we", mem_we, 1'h1);
      check("zero", zero_flag, (a | m) == 8'h00);
      run(OP_MEMORY_ROTATE_LEFT, 8'h00, m, 11'h000);
      pause();
      check("rotate", mem_wdata, {m[6:0], m[7]});
      check("rotate we", mem_we, 1'h1);
      z = zero_flag;
      run(seed[28] ? OP_SUBROUTINE_EXIT : OP_INTERRUPT_EXIT, 8'h00, m, ~seed[26:16]);
      check("pop", stack_pop, 1'h1);
      check("load", pc_load, 1'h1);
      check("pc", pc_value, ~seed[26:16]);
      check("zero kept", zero_flag, z);
      if (!seed[28]) check("enable", master_interrupt_enable, 1'h1);
      $display("test %0d done", i);
    end
    op_valid = 1'h0; mie_clear = 1'h1; int_request = 1'h1;
    @(posedge clock);
    #1 mie_clear = 1'h0;
    repeat (3) @(posedge clock);
    #1 run(OP_INTERRUPT_EXIT, 8'h00, 8'h00, 11'h2A5);
    check("pc", pc_value, 11'h2A5);
    check("enable set", master_interrupt_enable, 1'h1);
    pause();
    check("ack", int_ack, 1'h1);
    check("push strobe", stack_push, 1'h1);
    check("push", push_addr, 11'h2A5);
    check("vector", pc_value, VEC);
    acks = 11'h000;
    repeat (10) begin
      @(posedge clock);
      #1 acks = acks + int_ack;
    end
    check("gated", acks, 11'h000);
    $display("test pending interrupt done");
    int_request = 1'h0;
    repeat (3) @(posedge clock);
    #1 run(OP_INTERRUPT_EXIT, 8'h00, 8'h00, 11'h155);
    op_valid = 1'h0; int_request = 1'h1;
    repeat (4) @(posedge clock);
    #1 check("idle ack", int_ack, 1'h1);
    check("idle push", push_addr, 11'h155);
    check("idle vector", pc_value, VEC);
    check("idle masked", master_interrupt_enable, 1'h0);
    int_request = 1'h0;
    $display("test idle interrupt done");
    print_verdict();
  end
endmodule : tb
